// ===== rtl/usbdc_defs.vh
// Summary of operation
// - 16-bit bus option decodes endpoint FIFO ports on halfwords 20h..3Eh.
// - 32-bit bus decodes endpoint FIFO ports on words 20h..5Ch.
// - FIFO port write pushes transmit FIFO; read pops receive FIFO.
// - FIFO accesses carry one to four contiguous bytes; gaps are refused.
// - endpoint info register, read-only: rx count high nibble, tx count low.
// - memory info register, read-only: DMA channels high, RAM width-1 low.
// - power register bit 6 switches transceiver normal or non-driving.
// - attach bit set enables lines; Powered state ignores all but bus reset (code still rejects bad-length setups there).
// - attach bit clear puts transceiver non-driving, device appears detached.
// - hardware reset clears attach bit, device stays detached.
// - bus reset zeroes address and index, flushes, clears, enables, signals.
// - with high-speed allow set, negotiate during reset, report in bit 4.
// - 3 ms bus idle enters suspend, suspend event if enabled.
// - suspend drives SUSPENDM low only when sleep-allow bit 0 is set.
// - with clock running, resume signalling wakes transceiver, resume event.
// - no resume event when software started the wakeup.
// - setup packets whose command length is not eight bytes are rejected.
`ifndef USBDC_DEFS_VH
`define USBDC_DEFS_VH

`define USBDC_A_POWER      8'h00
`define USBDC_A_FUNCTION_ADDRESS      8'h04
`define USBDC_A_INDEX      8'h08
`define USBDC_A_RDWIDTH    8'h0C
`define USBDC_A_EVT_EN     8'h10
`define USBDC_A_EP_INT_EN  8'h14
`define USBDC_A_ENDPOINT_COUNT_INFO     8'h18
`define USBDC_A_MEMORY_DMA_INFO    8'h1C
`define USBDC_A_FIFO_BASE  8'h20
`define USBDC_A_FIFO_END16 8'h3F
`define USBDC_A_FIFO_END32 8'h5F

`define USBDC_PWR_SLEEP    0
`define USBDC_PWR_SUSP     1
`define USBDC_PWR_RESUME   2
`define USBDC_PWR_RESET    3
`define USBDC_PWR_HSACT    4
`define USBDC_PWR_HSALLOW  5
`define USBDC_PWR_ATTACH   6

`define USBDC_EVT_SUSP     0
`define USBDC_EVT_RESUME   1
`define USBDC_EVT_RESET    2

`define USBDC_RDWIDTH_RST  3'h4
`define USBDC_EVT_EN_RST   3'h7
`define USBDC_EP_INT_ALL   32'hFFFFFFFF
`define USBDC_SETUP_LEN    7'h08

`define USBDC_LS_SE0       2'h0
`define USBDC_LS_J         2'h1
`define USBDC_LS_K         2'h2
`define USBDC_OP_NORMAL    2'h0
`define USBDC_OP_NODRIVE   2'h1
`define USBDC_OP_RAWK      2'h2

`define USBDC_RESP_OKAY    2'h0
`define USBDC_RESP_SLVERR  2'h2

`define USBDC_CLK_KHZ      20000
`define USBDC_IDLE_MS      3
`define USBDC_RST_SE0_NS   2500
`define USBDC_CNT_W        20

`endif

// ===== rtl/usbdc_top.v
`timescale 1ns/100ps
`include "usbdc_defs.vh"
module usbdc_top #(
  parameter       BUS16       = 0,
  parameter [3:0] RX_EP_COUNT = 4'hF,
  parameter [3:0] TX_EP_COUNT = 4'hF,
  parameter [3:0] DMA_CHANS   = 4'h0,
  parameter [3:0] RAM_AW_M1   = 4'hB,
  parameter       IDLE_CYCLES = `USBDC_IDLE_MS * `USBDC_CLK_KHZ
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg         TX_PUSH,
  output reg  [3:0]  TX_EP,
  output reg  [31:0] TX_DATA,
  output reg  [3:0]  TX_STRB,
  input  wire        TX_READY,
  output wire        RX_POP,
  output wire [3:0]  RX_EP,
  output wire [2:0]  RX_BYTES,
  input  wire [31:0] RX_DATA,
  input  wire        RX_VALID,
  input  wire [1:0]  LINESTATE,
  input  wire        HS_CHIRP_OK,
  output reg  [1:0]  OPMODE,
  output reg         SUSPENDM,
  output reg         XCVR_HS,
  output reg         CHIRP_EN,
  output reg         RESUME_DRIVE,
  output reg         LINK_ACTIVE,
  input  wire        SETUP_DONE,
  input  wire [6:0]  SETUP_LEN,
  output reg         SETUP_ACCEPT,
  output reg         SETUP_REJECT,
  output reg  [6:0]  FUNC_ADDR,
  output reg  [3:0]  EP_INDEX,
  output reg  [31:0] EP_INT_EN,
  output reg         FIFO_FLUSH,
  output reg         CSR_CLEAR,
  output reg         EVT_RESET,
  output reg         EVT_SUSPEND,
  output reg         EVT_RESUME
);

  localparam integer RST_CYC = (`USBDC_RST_SE0_NS * `USBDC_CLK_KHZ + 999999) / 1000000;
  // counts are cut to the counter width on purpose; both defaults fit
  localparam [`USBDC_CNT_W-1:0] IDLE_CNT = IDLE_CYCLES[`USBDC_CNT_W-1:0];
  localparam [`USBDC_CNT_W-1:0] RST_CNT  = RST_CYC[`USBDC_CNT_W-1:0];

  localparam [2:0] ST_DETACHED = 3'h0;
  localparam [2:0] ST_POWERED  = 3'h1;
  localparam [2:0] ST_RESET    = 3'h2;
  localparam [2:0] ST_ACTIVE   = 3'h3;
  localparam [2:0] ST_SUSPEND  = 3'h4;

  // bytes in a strobe pattern, zero when lanes are not contiguous
  function [2:0] strb_bytes;
    input [3:0] s;
    begin
      case (s)
        4'h1, 4'h2, 4'h4, 4'h8: strb_bytes = 3'h1;
        4'h3, 4'h6, 4'hC:       strb_bytes = 3'h2;
        4'h7, 4'hE:             strb_bytes = 3'h3;
        4'hF:                   strb_bytes = 3'h4;
        default:                strb_bytes = 3'h0;
      endcase
    end
  endfunction

  function fifo_hit;
    input [7:0] a;
    begin
      if (BUS16 != 0)
        fifo_hit = (a >= `USBDC_A_FIFO_BASE) && (a <= `USBDC_A_FIFO_END16) && !a[0];
      else
        fifo_hit = (a >= `USBDC_A_FIFO_BASE) && (a <= `USBDC_A_FIFO_END32)
                   && (a[1:0] == 2'h0);
    end
  endfunction

  function [3:0] fifo_ep;
    input [7:0] a;
    reg   [7:0] off;
    begin
      off = a - `USBDC_A_FIFO_BASE;
      fifo_ep = (BUS16 != 0) ? off[4:1] : off[5:2];
    end
  endfunction

  reg         aw_q;
  reg  [7:0]  awaddr_q;
  reg         w_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         attach_q;
  reg         sleep_q;
  reg         resume_q;
  reg         hs_allow_q;
  reg         hs_act_q;
  reg  [2:0]  rdwidth_q;
  reg  [2:0]  evt_en_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [`USBDC_CNT_W-1:0] se0_cnt_q;
  reg  [`USBDC_CNT_W-1:0] idle_cnt_q;
  reg         sw_wake_q;

  wire        wr_go   = aw_q && w_q && !S_AXI_BVALID;
  wire        wr_fifo = fifo_hit(awaddr_q);
  wire [2:0]  wr_nb   = strb_bytes(wstrb_q);
  // a push waits for room; a gapped strobe is answered with an error
  wire        wr_fire = wr_go && (!wr_fifo || TX_READY || wr_nb == 3'h0);
  wire        rd_go   = S_AXI_ARVALID && !S_AXI_RVALID;
  wire        rd_fifo = fifo_hit(S_AXI_ARADDR);
  wire        ls_se0  = (LINESTATE == `USBDC_LS_SE0);
  wire        ls_idle = (LINESTATE == `USBDC_LS_J) || (hs_act_q && ls_se0);
  wire        bus_rst = (se0_cnt_q == RST_CNT) && !hs_act_q;
  wire        in_susp = (state_q == ST_SUSPEND);
  wire        wr_pwr  = wr_fire && awaddr_q == `USBDC_A_POWER && wstrb_q[0];

  assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_q && !S_AXI_BVALID;
  // a read that hits a FIFO port waits until the receive side has data
  assign S_AXI_ARREADY = !S_AXI_RVALID && (!rd_fifo || RX_VALID);
  assign RX_POP        = rd_go && rd_fifo && RX_VALID;
  assign RX_EP         = fifo_ep(S_AXI_ARADDR);
  assign RX_BYTES      = rdwidth_q;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_q         <= 1'b0;
      awaddr_q     <= 8'h00;
      w_q          <= 1'b0;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `USBDC_RESP_OKAY;
      TX_PUSH      <= 1'b0;
      TX_EP        <= 4'h0;
      TX_DATA      <= 32'h00000000;
      TX_STRB      <= 4'h0;
    end else begin
      TX_PUSH <= 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q     <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q     <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (wr_fire) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= `USBDC_RESP_OKAY;
        if (wr_fifo) begin
          if (wr_nb == 3'h0) begin
            S_AXI_BRESP <= `USBDC_RESP_SLVERR;
          end else begin
            TX_PUSH <= 1'b1;
            TX_EP   <= fifo_ep(awaddr_q);
            TX_DATA <= wdata_q;
            TX_STRB <= wstrb_q;
          end
        end else if (awaddr_q > `USBDC_A_EP_INT_EN || awaddr_q[1:0] != 2'h0) begin
          S_AXI_BRESP <= `USBDC_RESP_SLVERR;
        end
      end
    end
  end

  // read side; data are captured in the cycle the address is taken
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= `USBDC_RESP_OKAY;
    end else begin
      if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
      if (rd_go && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `USBDC_RESP_OKAY;
        S_AXI_RDATA  <= 32'h00000000;
        if (rd_fifo) begin
          S_AXI_RDATA <= RX_DATA;
        end else begin
          case (S_AXI_ARADDR)
            `USBDC_A_POWER: begin
              S_AXI_RDATA[`USBDC_PWR_SLEEP]   <= sleep_q;
              S_AXI_RDATA[`USBDC_PWR_SUSP]    <= in_susp;
              S_AXI_RDATA[`USBDC_PWR_RESUME]  <= resume_q;
              S_AXI_RDATA[`USBDC_PWR_RESET]   <= (state_q == ST_RESET);
              S_AXI_RDATA[`USBDC_PWR_HSACT]   <= hs_act_q;
              S_AXI_RDATA[`USBDC_PWR_HSALLOW] <= hs_allow_q;
              S_AXI_RDATA[`USBDC_PWR_ATTACH]  <= attach_q;
            end
            `USBDC_A_FUNCTION_ADDRESS:     S_AXI_RDATA[6:0] <= FUNC_ADDR;
            `USBDC_A_INDEX:     S_AXI_RDATA[3:0] <= EP_INDEX;
            `USBDC_A_RDWIDTH:   S_AXI_RDATA[2:0] <= rdwidth_q;
            `USBDC_A_EVT_EN:    S_AXI_RDATA[2:0] <= evt_en_q;
            `USBDC_A_EP_INT_EN: S_AXI_RDATA      <= EP_INT_EN;
            `USBDC_A_ENDPOINT_COUNT_INFO:    S_AXI_RDATA[7:0] <= {RX_EP_COUNT, TX_EP_COUNT};
            `USBDC_A_MEMORY_DMA_INFO:   S_AXI_RDATA[7:0] <= {DMA_CHANS, RAM_AW_M1};
            default:            S_AXI_RRESP      <= `USBDC_RESP_SLVERR;
          endcase
        end
      end
    end
  end

  // link state; only a bus reset or clearing the attach bit moves the device out of Powered
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_DETACHED: if (attach_q) state_d = ST_POWERED;
      ST_POWERED:  if (bus_rst) state_d = ST_RESET;
      ST_RESET:    if (!ls_se0) state_d = ST_ACTIVE;
      ST_ACTIVE: begin
        if (bus_rst)
          state_d = ST_RESET;
        else if (idle_cnt_q == IDLE_CNT)
          state_d = ST_SUSPEND;
      end
      ST_SUSPEND: begin
        if (bus_rst)
          state_d = ST_RESET;
        else if (sw_wake_q && !resume_q)
          state_d = ST_ACTIVE;
        else if (!sw_wake_q && !resume_q && LINESTATE == `USBDC_LS_K)
          state_d = ST_ACTIVE;
      end
      default:     state_d = ST_DETACHED;
    endcase
    if (!attach_q)
      state_d = ST_DETACHED;
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q    <= ST_DETACHED;
      se0_cnt_q  <= {`USBDC_CNT_W{1'b0}};
      idle_cnt_q <= {`USBDC_CNT_W{1'b0}};
      sw_wake_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (!ls_se0 || state_q == ST_DETACHED || state_q == ST_RESET)
        se0_cnt_q <= {`USBDC_CNT_W{1'b0}};
      else if (se0_cnt_q != RST_CNT)
        se0_cnt_q <= se0_cnt_q + 1'b1;
      // any non-idle line state counts as activity and restarts the wait
      if (!ls_idle || state_q != ST_ACTIVE)
        idle_cnt_q <= {`USBDC_CNT_W{1'b0}};
      else if (idle_cnt_q != IDLE_CNT)
        idle_cnt_q <= idle_cnt_q + 1'b1;
      if (state_d != ST_SUSPEND)
        sw_wake_q <= 1'b0;
      else if (in_susp && resume_q)
        sw_wake_q <= 1'b1;
    end
  end

  // software registers; a bus reset overrides a same-cycle write to address, index, interrupt enables or resume bit
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      attach_q   <= 1'b0;
      sleep_q    <= 1'b0;
      resume_q   <= 1'b0;
      hs_allow_q <= 1'b0;
      rdwidth_q  <= `USBDC_RDWIDTH_RST;
      evt_en_q   <= `USBDC_EVT_EN_RST;
      FUNC_ADDR  <= 7'h00;
      EP_INDEX   <= 4'h0;
      EP_INT_EN  <= `USBDC_EP_INT_ALL;
    end else begin
      if (wr_pwr) begin
        attach_q   <= wdata_q[`USBDC_PWR_ATTACH];
        sleep_q    <= wdata_q[`USBDC_PWR_SLEEP];
        resume_q   <= wdata_q[`USBDC_PWR_RESUME];
        hs_allow_q <= wdata_q[`USBDC_PWR_HSALLOW];
      end
      if (wr_fire && wstrb_q[0]) begin
        case (awaddr_q)
          `USBDC_A_FUNCTION_ADDRESS:   FUNC_ADDR <= wdata_q[6:0];
          `USBDC_A_INDEX:   EP_INDEX  <= wdata_q[3:0];
          `USBDC_A_RDWIDTH: if (wdata_q[2:0] != 3'h0 && wdata_q[2:0] <= 3'h4)
                              rdwidth_q <= wdata_q[2:0];
          `USBDC_A_EVT_EN:  evt_en_q  <= wdata_q[2:0];
          default:          ;
        endcase
      end
      if (wr_fire && awaddr_q == `USBDC_A_EP_INT_EN && wstrb_q == 4'hF)
        EP_INT_EN <= wdata_q;
      if (state_d == ST_RESET && state_q != ST_RESET) begin
        FUNC_ADDR <= 7'h00;
        EP_INDEX  <= 4'h0;
        EP_INT_EN <= `USBDC_EP_INT_ALL;
        resume_q  <= 1'b0;
      end
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hs_act_q     <= 1'b0;
      OPMODE       <= `USBDC_OP_NODRIVE;
      SUSPENDM     <= 1'b1;
      XCVR_HS      <= 1'b0;
      CHIRP_EN     <= 1'b0;
      RESUME_DRIVE <= 1'b0;
      LINK_ACTIVE  <= 1'b0;
      FIFO_FLUSH   <= 1'b0;
      CSR_CLEAR    <= 1'b0;
      EVT_RESET    <= 1'b0;
      EVT_SUSPEND  <= 1'b0;
      EVT_RESUME   <= 1'b0;
      SETUP_ACCEPT <= 1'b0;
      SETUP_REJECT <= 1'b0;
    end else begin
      if (state_d == ST_DETACHED || (state_d == ST_RESET && state_q != ST_RESET))
        hs_act_q <= 1'b0;
      else if (state_q == ST_RESET && state_d == ST_ACTIVE)
        hs_act_q <= hs_allow_q && HS_CHIRP_OK;
      if (state_d == ST_DETACHED)
        OPMODE <= `USBDC_OP_NODRIVE;
      else if (state_d == ST_SUSPEND && resume_q)
        OPMODE <= `USBDC_OP_RAWK;
      else
        OPMODE <= `USBDC_OP_NORMAL;
      // sleep only while no remote wakeup is being driven
      SUSPENDM     <= !(state_d == ST_SUSPEND && sleep_q && !resume_q);
      XCVR_HS      <= hs_act_q;
      CHIRP_EN     <= (state_d == ST_RESET) && hs_allow_q;
      RESUME_DRIVE <= (state_d == ST_SUSPEND) && resume_q;
      LINK_ACTIVE  <= (state_d == ST_ACTIVE);
      FIFO_FLUSH   <= (state_d == ST_RESET) && (state_q != ST_RESET);
      CSR_CLEAR    <= (state_d == ST_RESET) && (state_q != ST_RESET);
      EVT_RESET    <= (state_d == ST_RESET) && (state_q != ST_RESET)
                      && evt_en_q[`USBDC_EVT_RESET];
      EVT_SUSPEND  <= (state_d == ST_SUSPEND) && !in_susp
                      && evt_en_q[`USBDC_EVT_SUSP];
      EVT_RESUME   <= in_susp && (state_d == ST_ACTIVE) && !sw_wake_q
                      && evt_en_q[`USBDC_EVT_RESUME];
      SETUP_ACCEPT <= SETUP_DONE && (SETUP_LEN == `USBDC_SETUP_LEN) && LINK_ACTIVE;
      SETUP_REJECT <= SETUP_DONE && (SETUP_LEN != `USBDC_SETUP_LEN);
    end
  end

endmodule // usbdc_top

// ===== dv/usbdc_host_model.sv
`timescale 1ns/100ps
`include "usbdc_defs.vh"
module usbdc_host_model (
  input  wire        CLK,
  input  wire [3:0]  RX_EP,
  input  wire [1:0]  OPMODE,
  input  wire        SUSPENDM,
  output wire [1:0]  LINESTATE,
  output reg         HS_CHIRP_OK,
  output wire [31:0] RX_DATA,
  output wire        RX_VALID,
  output wire        TX_READY,
  output wire        WAKE_EVT
);
  reg [1:0] ls_q = `USBDC_LS_J;
  initial HS_CHIRP_OK = 1'b0;
  // detached: no pull-up on either line, so the host sees SE0
  assign LINESTATE = (OPMODE == `USBDC_OP_NODRIVE) ? `USBDC_LS_SE0 :
                     (OPMODE == `USBDC_OP_RAWK) ? `USBDC_LS_K : ls_q;
  assign RX_DATA  = {24'h5A5A5A, 4'h0, RX_EP};
  assign RX_VALID = 1'b1;
  assign TX_READY = 1'b1;
  // what outside logic would use to restart a stopped core clock
  assign WAKE_EVT = !SUSPENDM && (LINESTATE == `USBDC_LS_K || LINESTATE == `USBDC_LS_SE0);
  task line(input [1:0] v, input ok);
    begin
      @(posedge CLK);
      ls_q <= v;
      HS_CHIRP_OK <= ok;
    end
  endtask
endmodule // usbdc_host_model

// ===== dv/usbdc_assertions.sv
`timescale 1ns/100ps
`include "usbdc_defs.vh"
module usbdc_assertions #(
  parameter IDLE_CYCLES = 60000
) (
  input wire        CLK,
  input wire        RST_N,
  input wire [7:0]  S_AXI_ARADDR,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire        TX_PUSH,
  input wire [3:0]  TX_STRB,
  input wire        RX_POP,
  input wire        RX_VALID,
  input wire [1:0]  LINESTATE,
  input wire [1:0]  OPMODE,
  input wire        SUSPENDM,
  input wire        XCVR_HS,
  input wire        RESUME_DRIVE,
  input wire        LINK_ACTIVE,
  input wire        SETUP_DONE,
  input wire [6:0]  SETUP_LEN,
  input wire        SETUP_ACCEPT,
  input wire        SETUP_REJECT,
  input wire [6:0]  FUNC_ADDR,
  input wire [3:0]  EP_INDEX,
  input wire [31:0] EP_INT_EN,
  input wire        FIFO_FLUSH,
  input wire        CSR_CLEAR,
  input wire        EVT_SUSPEND,
  input wire        EVT_RESUME
);
  reg [19:0] idle_q;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) idle_q <= 20'h0;
    else if (LINESTATE == `USBDC_LS_J || (XCVR_HS && LINESTATE == `USBDC_LS_SE0))
      idle_q <= idle_q + 20'h1;
    else
      idle_q <= 20'h0;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_reset_detached: assert property ($rose(RST_N) |-> OPMODE == `USBDC_OP_NODRIVE && SUSPENDM)
    else $error("not detached after reset");
  a_detach_quiet: assert property (OPMODE == `USBDC_OP_NODRIVE |-> !LINK_ACTIVE && !RESUME_DRIVE)
    else $error("active while detached");
  a_setup_reject: assert property (SETUP_DONE && SETUP_LEN != 7'h08 |=> SETUP_REJECT && !SETUP_ACCEPT)
    else $error("bad setup length not rejected");
  a_setup_keep: assert property (SETUP_DONE && SETUP_LEN == 7'h08 |=>
    !SETUP_REJECT && SETUP_ACCEPT == $past(LINK_ACTIVE)) else $error("good setup mishandled");
  a_reset_effects: assert property (FIFO_FLUSH |-> CSR_CLEAR ##1
    (FUNC_ADDR == 7'h00 && EP_INDEX == 4'h0 && EP_INT_EN == 32'hFFFFFFFF))
    else $error("bus reset actions incomplete");
  a_push_contig: assert property (TX_PUSH |-> TX_STRB inside {4'h1, 4'h2, 4'h4, 4'h8,
    4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF}) else $error("push with gapped lanes");
  a_pop_cause: assert property (RX_POP |-> S_AXI_ARVALID && S_AXI_ARREADY && RX_VALID &&
    S_AXI_ARADDR >= 8'h20) else $error("pop without fifo read");
  a_suspend_idle: assert property (EVT_SUSPEND |-> idle_q >= IDLE_CYCLES - 1)
    else $error("suspend before idle time");
  a_resume_k: assert property (RESUME_DRIVE |-> OPMODE == `USBDC_OP_RAWK && SUSPENDM)
    else $error("resume drive without raw K");
  a_no_sw_resume: assert property (EVT_RESUME |-> !$past(RESUME_DRIVE))
    else $error("resume event after remote wakeup");
  a_sleep_idle: assert property (!SUSPENDM |-> !LINK_ACTIVE)
    else $error("transceiver asleep while active");
  c_suspend: cover property (EVT_SUSPEND);
  c_remote: cover property (RESUME_DRIVE);
  c_reject: cover property (SETUP_REJECT);
endmodule // usbdc_assertions
bind usbdc_top usbdc_assertions #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (.*);

// ===== dv/usb_function_device_control_bench.sv
`timescale 1ns/100ps
`include "usbdc_defs.vh"
module usb_function_device_control_bench;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [3:0] s;
    logic [1:0] r; logic [31:0] q;} usbdc_row_t;
  localparam [1:0] OK = `USBDC_RESP_OKAY;
  localparam [1:0] ER = `USBDC_RESP_SLVERR;
  logic        CLK = 0, RST_N = 0, SETUP_DONE = 0;
  logic [7:0]  S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0;
  logic [3:0]  S_AXI_WSTRB = 0;
  logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic [6:0]  SETUP_LEN = 0;
  wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire [1:0]   S_AXI_BRESP, S_AXI_RRESP, LINESTATE, OPMODE;
  wire [31:0]  S_AXI_RDATA, TX_DATA, RX_DATA, EP_INT_EN;
  wire [3:0]   TX_EP, TX_STRB, RX_EP, EP_INDEX, ep16;
  wire         TX_PUSH, TX_READY, RX_POP, RX_VALID, HS_CHIRP_OK, SUSPENDM, XCVR_HS;
  wire         CHIRP_EN, RESUME_DRIVE, LINK_ACTIVE, SETUP_ACCEPT, SETUP_REJECT, WAKE_EVT;
  wire         FIFO_FLUSH, CSR_CLEAR, EVT_RESET, EVT_SUSPEND, EVT_RESUME;
  wire [2:0]   RX_BYTES;
  wire [6:0]   FUNC_ADDR;
  integer      miscompares = 0, cmp_count = 0, cyc = 0, n_rst = 0, n_sus = 0, n_res = 0;
  integer      n_push = 0, n_pop = 0, n_fl = 0;
  integer      i, j, k;
  logic [31:0] d;
  logic [1:0]  r;
  logic        acc, rej;
  usbdc_row_t  rows [0:9];
  usbdc_top #(.RX_EP_COUNT(4'h3), .TX_EP_COUNT(4'h5), .DMA_CHANS(4'h2), .RAM_AW_M1(4'hA),
    .IDLE_CYCLES(200)) uut (.*);
  usbdc_host_model host (.*);
  // 16-bit bus copy, shadows the same traffic; only its port decode is looked at
  usbdc_top #(.BUS16(1)) uut16 (.*, .S_AXI_AWREADY(), .S_AXI_WREADY(), .S_AXI_BRESP(),
    .S_AXI_BVALID(), .S_AXI_ARREADY(), .S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(),
    .TX_PUSH(), .TX_EP(), .TX_DATA(), .TX_STRB(), .RX_POP(), .RX_EP(ep16), .RX_BYTES(),
    .OPMODE(), .SUSPENDM(), .XCVR_HS(), .CHIRP_EN(), .RESUME_DRIVE(), .LINK_ACTIVE(),
    .SETUP_ACCEPT(), .SETUP_REJECT(), .FUNC_ADDR(), .EP_INDEX(), .EP_INT_EN(),
    .FIFO_FLUSH(), .CSR_CLEAR(), .EVT_RESET(), .EVT_SUSPEND(), .EVT_RESUME());
  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    n_rst <= n_rst + (EVT_RESET === 1'b1);
    n_sus <= n_sus + (EVT_SUSPEND === 1'b1);
    n_res <= n_res + (EVT_RESUME === 1'b1);
    n_push <= n_push + (TX_PUSH === 1'b1);
    n_pop <= n_pop + (RX_POP === 1'b1);
    n_fl <= n_fl + (FIFO_FLUSH === 1'b1 && CSR_CLEAR === 1'b1);
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      results;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [3:0] s, output [1:0] rs);
    logic pa, pw, ta, tw, tb;
    begin
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= v;
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      tb = 1'b0;
      // readies are sampled settled, just ahead of the edge that takes them
      while (pa || pw) begin
        @(negedge CLK);
        ta = pa && S_AXI_AWREADY;
        tw = pw && S_AXI_WREADY;
        @(posedge CLK);
        if (ta) S_AXI_AWVALID <= 1'b0;
        if (tw) S_AXI_WVALID <= 1'b0;
        pa = pa && !ta;
        pw = pw && !tw;
      end
      while (!tb) begin
        @(negedge CLK);
        tb = S_AXI_BVALID;
        rs = S_AXI_BRESP;
        @(posedge CLK);
      end
      S_AXI_BREADY <= 1'b0;
      repeat (2) @(negedge CLK);
    end
  endtask
  task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
    logic ta, tr;
    begin
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      ta = 1'b0;
      tr = 1'b0;
      while (!ta) begin
        @(negedge CLK);
        ta = S_AXI_ARREADY;
        @(posedge CLK);
      end
      S_AXI_ARVALID <= 1'b0;
      while (!tr) begin
        @(negedge CLK);
        tr = S_AXI_RVALID;
        v = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        @(posedge CLK);
      end
      S_AXI_RREADY <= 1'b0;
    end
  endtask
  task setup(input [6:0] n);
    begin
      @(posedge CLK);
      SETUP_DONE <= 1'b1;
      SETUP_LEN <= n;
      @(posedge CLK);
      SETUP_DONE <= 1'b0;
      @(negedge CLK);
      acc = SETUP_ACCEPT;
      rej = SETUP_REJECT;
    end
  endtask
  task waitsus;
    // suspend is awaited only after reset and setup work is serviced
    begin
      k = n_sus;
      j = 0;
      while (n_sus == k && j < 600) begin
        @(posedge CLK);
        j = j + 1;
      end
      @(negedge CLK);
      chk(n_sus, k + 1);
    end
  endtask
  initial begin
    rows[0] = '{1'b0, 8'h18, 32'h0, 4'h0, OK, 32'h35};
    rows[1] = '{1'b0, 8'h1C, 32'h0, 4'h0, OK, 32'h2A};
    rows[2] = '{1'b0, 8'h60, 32'h0, 4'h0, ER, 32'h0};
    rows[3] = '{1'b1, 8'h22, 32'h0, 4'hF, ER, 32'h0};
    rows[4] = '{1'b1, 8'h5C, 32'h0, 4'h5, ER, 32'h0};
    // endpoints 0, 15, 8 and 1 each get a single transfer, one width per packet
    rows[5] = '{1'b1, 8'h20, 32'h11223344, 4'hF, OK, 32'h0};
    rows[6] = '{1'b1, 8'h5C, 32'h00AABB00, 4'h6, OK, 32'h0};
    rows[7] = '{1'b1, 8'h40, 32'h000000CC, 4'h1, OK, 32'h0};
    rows[8] = '{1'b1, 8'h24, 32'h00DDEEFF, 4'h7, OK, 32'h0};
    rows[9] = '{1'b0, 8'h5C, 32'h0, 4'h0, OK, 32'h5A5A5A0F};
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    chk({OPMODE, SUSPENDM}, {`USBDC_OP_NODRIVE, 1'b1});
    for (i = 0; i < 10; i = i + 1) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].s, r);
      else rd(rows[i].a, d, r);
      chk(r, rows[i].r);
      if (!rows[i].w && r === OK)
        chk(rows[i].a < 8'h20 ? {24'h0, d[7:0]} : d, rows[i].q);
      if (rows[i].w && r === OK) begin
        chk(TX_DATA, rows[i].d);
        chk({TX_EP, TX_STRB}, {(rows[i].a - 8'h20) >> 2, rows[i].s});
      end
    end
    chk({n_push[3:0], n_pop[3:0]}, 8'h41);
    rd(8'h3E, d, r);
    chk({r, ep16}, {ER, 4'hF});
    rd(8'h22, d, r);
    chk({r, ep16}, {ER, 4'h1});
    wr(8'h0C, 32'h2, 4'h1, r);
    chk(RX_BYTES, 3'h2);
    wr(8'h00, 32'h61, 4'h1, r);
    chk({OPMODE, LINK_ACTIVE}, {`USBDC_OP_NORMAL, 1'b0});
    host.line(`USBDC_LS_K, 1'b0);
    repeat (20) @(posedge CLK);
    host.line(`USBDC_LS_J, 1'b0);
    setup(7'h08);
    chk({acc, rej, LINK_ACTIVE, n_res[0]}, 4'b0000);
    setup(7'h07);
    chk({acc, rej}, 2'b01);
    wr(8'h04, 32'h15, 4'h1, r);
    wr(8'h08, 32'h3, 4'h1, r);
    wr(8'h14, 32'h0, 4'hF, r);
    chk(EP_INT_EN, 32'h0);
    host.line(`USBDC_LS_SE0, 1'b0);
    repeat (60) @(posedge CLK);
    @(negedge CLK);
    chk(CHIRP_EN, 1'b1);
    host.line(`USBDC_LS_J, 1'b0);
    repeat (3) @(negedge CLK);
    chk({FUNC_ADDR, EP_INDEX, XCVR_HS, LINK_ACTIVE}, {11'h0, 2'b01});
    chk({n_rst[3:0], n_fl[3:0]}, 8'h11);
    chk(EP_INT_EN, `USBDC_EP_INT_ALL);
    rd(8'h04, d, r);
    chk(d[6:0], 7'h00);
    setup(7'h08);
    chk({acc, rej}, 2'b10);
    wr(8'h00, 32'h61, 4'h1, r);
    waitsus;
    chk(SUSPENDM, 1'b0);
    host.line(`USBDC_LS_K, 1'b0);
    @(negedge CLK);
    chk(WAKE_EVT, 1'b1);
    repeat (20) @(posedge CLK);
    host.line(`USBDC_LS_J, 1'b0);
    repeat (2) @(negedge CLK);
    chk({SUSPENDM, LINK_ACTIVE, n_res[1:0]}, 4'b1101);
    wr(8'h00, 32'h60, 4'h1, r);
    waitsus;
    chk(SUSPENDM, 1'b1);
    wr(8'h00, 32'h64, 4'h1, r);
    chk({OPMODE, RESUME_DRIVE, SUSPENDM}, {`USBDC_OP_RAWK, 2'b11});
    // software holds the resume bit for the 2 ms minimum
    repeat (40000) @(posedge CLK);
    wr(8'h00, 32'h60, 4'h1, r);
    chk({RESUME_DRIVE, LINK_ACTIVE, n_res[1:0]}, 4'b0101);
    wr(8'h00, 32'h00, 4'h1, r);
    chk({OPMODE, LINK_ACTIVE}, {`USBDC_OP_NODRIVE, 1'b0});
    wr(8'h00, 32'h60, 4'h1, r);
    host.line(`USBDC_LS_SE0, 1'b1);
    repeat (60) @(posedge CLK);
    host.line(`USBDC_LS_J, 1'b1);
    repeat (3) @(negedge CLK);
    chk(XCVR_HS, 1'b1);
    rd(8'h00, d, r);
    chk(d[4], 1'b1);
    results;
  end
endmodule // usb_function_device_control_bench
